// ---- swrmc_sleep_wake_ctrl.sv ----
`default_nettype none
`include "swrmc_regs.svh"
// Overview of operation
// - in SLEEP only an interrupt or the sleep pin may wake
// - wake only from SLEEP, launching sleep_to_active_seq or sleep_to_off_seq
// - sleep pin is a level, active-low, maskable request, masked after reset
// - each resource takes its ACTIVE or SLEEP mode from its mode field
// - sleep-pin-only resources change mode only as a sequence step
// - enable-pin-only resources switch at once, ignoring any running sequence
// - sleep only when every assigned pin sits at its sleep level
// - unassigned resources never sleep; they leave their ACTIVE mode only when powered off
// - polarity of all three pins is selectable in a register
// - enable pins default active high, rising edge wakes their resources
// - sleep pin defaults active low, falling edge requests sleep
// - pin assignments held in one register per pin, fields grouped by resource class
// - resources assigned only to the same enable pin switch together
// - sleep-pin-only resources switch in the fixed sequence order
// - sequences drive switchers, linear regulators, 32 kHz clock and enable outputs
// - sequencer waits the programmed step interval between steps
// - uncovered resources follow their software enable, off in OFF; software writes it only outside sequences
module swrmc_sleep_wake_ctrl
  import swrmc_pkg::*;
#(
  parameter int          STEP_TIME_US = `SWRMC_STEP_TIME_US,
  parameter logic [7:0]  SEQ_COVER    = `SWRMC_SEQ_COVER
)(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        sleep_request_n_pin,
  input  wire logic        resource_enable_a_pin,
  input  wire logic        resource_enable_b_pin,
  input  wire logic        irq_pending,
  input  wire logic        wake_irq,
  output logic [15:0]      res_mode,
  output logic [7:0]       res_sleep,
  output logic [7:0]       res_on,
  output logic             seq_busy
);
  swrmc_main_t st_q;
  swrmc_main_t st_d;
  logic        slp_level;
  logic        ena_level;
  logic        enb_level;
  logic        slp_req;
  logic        in_seq;
  logic [2:0]  ord;
  logic        wr_en;
  logic        ap_take;
  logic [7:0]  enb_only;
  swrmc_step_if step ();

  // pin levels registered on clk, polarity already folded in
  swrmc_pin_sampler u_slp (
    .clk         (clk),
    .srst        (srst),
    .pin         (sleep_request_n_pin),
    .active_high (st_q.pol[`SWRMC_POL_SLEEP]),
    .asserted_q  (slp_level)
  );
  swrmc_pin_sampler u_ena (
    .clk         (clk),
    .srst        (srst),
    .pin         (resource_enable_a_pin),
    .active_high (st_q.pol[`SWRMC_POL_ENA]),
    .asserted_q  (ena_level)
  );
  swrmc_pin_sampler u_enb (
    .clk         (clk),
    .srst        (srst),
    .pin         (resource_enable_b_pin),
    .active_high (st_q.pol[`SWRMC_POL_ENB]),
    .asserted_q  (enb_level)
  );

  swrmc_step_timer #(
    .STEP_US (STEP_TIME_US),
    .TICK    (`SWRMC_TICK_CYCLES)
  ) u_tmr (
    .clk  (clk),
    .srst (srst),
    .step (step)
  );

  // level request gated by the mask bit
  assign slp_req    = slp_level && !st_q.ctrl[`SWRMC_CTRL_SLEEP_MASK];
  assign in_seq     = (st_q.state == ST_A2S) || (st_q.state == ST_S2A) || (st_q.state == ST_S2OFF);
  assign ord        = (st_q.state == ST_A2S) ? st_q.idx : 3'(NRES - 1) - st_q.idx;
  assign step.start = in_seq && st_q.step_wait;
  assign ap_take    = hsel && hready && htrans[1];
  assign wr_en      = st_q.ap_valid && st_q.ap_write && st_q.ap_hit;

  // zero wait state slave, never errors
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = st_q.rdata;
  assign res_mode  = st_q.out_mode;
  assign res_sleep = st_q.out_sleep;
  assign res_on    = st_q.out_on;
  assign seq_busy  = in_seq;

  always_comb begin
    logic on_i;
    logic sleep_i;
    logic any_i;
    on_i    = 1'b0;
    sleep_i = 1'b0;
    any_i   = 1'b0;
    st_d    = st_q;

    // bus address phase captured, read data taken from the registers now
    st_d.ap_valid = ap_take;
    if (ap_take) begin
      st_d.ap_write = hwrite;
      st_d.ap_hit   = (haddr[31:5] == 27'h0) && (hsize == 3'h2);
      st_d.ap_idx   = haddr[4:2];
      st_d.rdata    = 32'h0;
      if (!hwrite && (haddr[31:5] == 27'h0)) begin
        unique case ({haddr[4:2], 2'b00})
          5'(`SWRMC_OFS_CTRL):       st_d.rdata = {30'h0, st_q.ctrl};
          5'(`SWRMC_OFS_POLARITY):   st_d.rdata = {29'h0, st_q.pol};
          5'(`SWRMC_OFS_SLEEP_ASGN): st_d.rdata = {24'h0, st_q.a_slp};
          5'(`SWRMC_OFS_ENA_ASGN):   st_d.rdata = {24'h0, st_q.a_ena};
          5'(`SWRMC_OFS_ENB_ASGN):   st_d.rdata = {24'h0, st_q.a_enb};
          5'(`SWRMC_OFS_MODE_CTRL):  st_d.rdata = st_q.mode;
          5'(`SWRMC_OFS_SW_EN):      st_d.rdata = {24'h0, st_q.sw_en};
          5'(`SWRMC_OFS_STATUS):     st_d.rdata = {7'h0, in_seq, st_q.out_on, st_q.out_sleep, 2'h0, st_q.state};
        endcase
      end
    end

    // data phase writes; assignment fields split misc[1:0] smps[4:2] ldo[7:5]
    if (wr_en) begin
      unique case ({st_q.ap_idx, 2'b00})
        5'(`SWRMC_OFS_CTRL):       st_d.ctrl  = hwdata[1:0];
        5'(`SWRMC_OFS_POLARITY):   st_d.pol   = hwdata[2:0];
        5'(`SWRMC_OFS_SLEEP_ASGN): st_d.a_slp = hwdata[7:0];
        5'(`SWRMC_OFS_ENA_ASGN):   st_d.a_ena = hwdata[7:0];
        5'(`SWRMC_OFS_ENB_ASGN):   st_d.a_enb = hwdata[7:0];
        5'(`SWRMC_OFS_MODE_CTRL):  st_d.mode  = hwdata;
        5'(`SWRMC_OFS_SW_EN): begin
          if (!in_seq) begin
            st_d.sw_en = hwdata[7:0];
          end
        end
        default: ;
      endcase
    end

    // power state sequencer; level requests seen mid-sequence act on return
    unique case (st_q.state)
      ST_ACTIVE: begin
        if (slp_req && !irq_pending) begin
          st_d.state     = ST_A2S;
          st_d.idx       = 3'h0;
          st_d.step_wait = 1'b0;
        end
      end
      ST_SLEEP: begin
        if (wake_irq || (!st_q.ctrl[`SWRMC_CTRL_SLEEP_MASK] && !slp_level)) begin
          st_d.state     = st_q.ctrl[`SWRMC_CTRL_WAKE_OFF] ? ST_S2OFF : ST_S2A;
          st_d.idx       = 3'h0;
          st_d.step_wait = 1'b0;
        end
      end
      ST_A2S, ST_S2A, ST_S2OFF: begin
        if (!st_q.step_wait) begin
          st_d.step_wait = 1'b1;
          if (st_q.state == ST_A2S) begin
            st_d.seq_sleep[ord] = st_q.a_slp[ord];
          end else if (st_q.state == ST_S2A) begin
            st_d.seq_sleep[ord] = 1'b0;
          end else begin
            st_d.seq_off[ord] = SEQ_COVER[ord];
          end
        end else if (step.done) begin
          st_d.step_wait = 1'b0;
          if (st_q.idx == 3'(NRES - 1)) begin
            unique case (st_q.state)
              ST_A2S:  st_d.state = ST_SLEEP;
              ST_S2A:  st_d.state = ST_ACTIVE;
              default: st_d.state = ST_OFF;
            endcase
          end else begin
            st_d.idx = st_q.idx + 3'h1;
          end
        end
      end
      ST_OFF: ;
      default: st_d.state = ST_ACTIVE;
    endcase

    // per resource mode; sampled enable pin levels feed the output flops directly, bypassing the sequencer
    for (int i = 0; i < NRES; i++) begin
      any_i   = st_q.a_slp[i] || st_q.a_ena[i] || st_q.a_enb[i];
      sleep_i = any_i && (!st_q.a_slp[i] || st_q.seq_sleep[i])
                      && (!st_q.a_ena[i] || !ena_level)
                      && (!st_q.a_enb[i] || !enb_level);
      on_i    = (st_q.state != ST_OFF) && (SEQ_COVER[i] ? !st_q.seq_off[i] : st_q.sw_en[i]);
      st_d.out_sleep[i] = sleep_i;
      st_d.out_on[i]    = on_i;
      st_d.out_mode[2*i +: 2] = !on_i ? `SWRMC_MODE_OFF :
                                (sleep_i ? st_q.mode[4*i+2 +: 2] : st_q.mode[4*i +: 2]);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q       <= '0;
      st_q.state <= ST_ACTIVE;
      st_q.ctrl  <= `SWRMC_CTRL_RST;
      st_q.pol   <= `SWRMC_POL_RST;
      st_q.mode  <= `SWRMC_MODE_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // helper: resources that only the second enable pin controls
  assign enb_only = st_q.a_enb & ~st_q.a_slp & ~st_q.a_ena;

  // state moves; a stray transition would power rails without a sequence
  a_sleep_irq_block : assert property (@(posedge clk) disable iff (srst)
    st_q.state == ST_ACTIVE && irq_pending |=> st_q.state == ST_ACTIVE)
    else $error("sleep began with irq pending");
  a_sleep_entry : assert property (@(posedge clk) disable iff (srst)
    st_q.state == ST_ACTIVE && slp_req && !irq_pending |=> st_q.state == ST_A2S && st_q.idx == 3'h0)
    else $error("sleep request not taken");
  a_sleep_hold : assert property (@(posedge clk) disable iff (srst)
    st_q.state == ST_SLEEP && !wake_irq && (slp_level || st_q.ctrl[0]) |=> st_q.state == ST_SLEEP)
    else $error("woke without wake source");
  a_wake_target : assert property (@(posedge clk) disable iff (srst)
    st_q.state == ST_SLEEP && wake_irq |=> (st_q.ctrl[1] ? st_q.state == ST_S2OFF : st_q.state == ST_S2A))
    else $error("wrong wake sequence");
  a_active_exit : assert property (@(posedge clk) disable iff (srst)
    st_q.state == ST_ACTIVE |=> st_q.state == ST_ACTIVE || st_q.state == ST_A2S)
    else $error("active left other than by sleep entry");
  a_off_terminal : assert property (@(posedge clk) disable iff (srst)
    st_q.state == ST_OFF |=> st_q.state == ST_OFF)
    else $error("off state left without reset");
  a_mask_reset : assert property (@(posedge clk)
    srst |=> st_q.ctrl[0] && st_q.pol == 3'h6)
    else $error("mask or polarity wrong after reset");

  // per resource mode; outputs trail the fields by one registered stage
  a_mode_select : assert property (@(posedge clk) disable iff (srst)
    st_q.out_on[0] |-> res_mode[1:0] == (res_sleep[0] ? $past(st_q.mode[3:2]) : $past(st_q.mode[1:0])))
    else $error("mode field mismatch");
  a_seq_only_change : assert property (@(posedge clk) disable iff (srst)
    !in_seq |=> $stable(st_q.seq_sleep))
    else $error("sequenced sleep changed outside sequence");
  a_enable_direct : assert property (@(posedge clk) disable iff (srst)
    st_q.a_ena[0] && ena_level ##1 st_q.a_ena[0] |-> !res_sleep[0])
    else $error("enable pin did not wake resource");
  a_enable_b_group : assert property (@(posedge clk) disable iff (srst)
    !enb_level && enb_only != 8'h00 |=> (res_sleep & $past(enb_only)) == $past(enb_only))
    else $error("shared enable resources did not sleep together");
  a_unassigned_active : assert property (@(posedge clk) disable iff (srst)
    st_q.a_slp[1] == 1'b0 && st_q.a_ena[1] == 1'b0 && st_q.a_enb[1] == 1'b0 |=> !res_sleep[1])
    else $error("unassigned resource slept");

  // register writes land at the edge that closes the data phase
  a_pol_write : assert property (@(posedge clk) disable iff (srst)
    wr_en && st_q.ap_idx == 3'h1 |=> st_q.pol == $past(hwdata[2:0]))
    else $error("polarity write lost");
  a_asgn_write : assert property (@(posedge clk) disable iff (srst)
    wr_en && st_q.ap_idx == 3'h2 |=> st_q.a_slp == $past(hwdata[7:0]))
    else $error("sleep pin assignment write lost");

  // one resource per step, and nothing advances while the step timer runs
  a_a2s_order : assert property (@(posedge clk) disable iff (srst)
    st_q.state == ST_A2S && !st_q.step_wait |=>
      st_q.seq_sleep == ($past(st_q.seq_sleep) | ($past(st_q.a_slp) & (8'h01 << $past(st_q.idx)))))
    else $error("sleep step out of order");
  a_s2a_order : assert property (@(posedge clk) disable iff (srst)
    st_q.state == ST_S2A && !st_q.step_wait |=>
      st_q.seq_sleep == ($past(st_q.seq_sleep) & ~(8'h80 >> $past(st_q.idx))))
    else $error("wake step out of order");
  a_step_hold : assert property (@(posedge clk) disable iff (srst)
    in_seq && st_q.step_wait && !step.done |=> $stable(st_q.state) && $stable(st_q.idx))
    else $error("sequence advanced before step interval");
  a_off_dark : assert property (@(posedge clk) disable iff (srst)
    st_q.state == ST_OFF |=> res_on == 8'h00)
    else $error("resource powered in off state");
  a_uncovered_swen : assert property (@(posedge clk) disable iff (srst)
    !SEQ_COVER[7] && st_q.state != ST_OFF |=> res_on[7] == $past(st_q.sw_en[7]))
    else $error("uncovered resource ignored software enable");
  a_swen_locked : assert property (@(posedge clk) disable iff (srst)
    in_seq |=> $stable(st_q.sw_en))
    else $error("software enable changed during sequence");
endmodule : swrmc_sleep_wake_ctrl
`default_nettype wire

// ---- swrmc_regs.svh ----
`ifndef SWRMC_REGS_SVH
`define SWRMC_REGS_SVH

// clock and time base
`define SWRMC_CLK_HZ          25000000
`define SWRMC_TICK_TIME_NS    1000
`define SWRMC_TICK_CYCLES     ((`SWRMC_TICK_TIME_NS * (`SWRMC_CLK_HZ / 1000000)) / 1000)
`define SWRMC_STEP_TIME_US    1000

// register byte offsets
`define SWRMC_OFS_CTRL        8'h00
`define SWRMC_OFS_POLARITY    8'h04
`define SWRMC_OFS_SLEEP_ASGN  8'h08
`define SWRMC_OFS_ENA_ASGN    8'h0C
`define SWRMC_OFS_ENB_ASGN    8'h10
`define SWRMC_OFS_MODE_CTRL   8'h14
`define SWRMC_OFS_SW_EN       8'h18
`define SWRMC_OFS_STATUS      8'h1C

// field positions
`define SWRMC_CTRL_SLEEP_MASK 0
`define SWRMC_CTRL_WAKE_OFF   1
`define SWRMC_POL_SLEEP       0
`define SWRMC_POL_ENA         1
`define SWRMC_POL_ENB         2

// reset values, default sequence cover and off mode code
`define SWRMC_CTRL_RST        2'h1
`define SWRMC_POL_RST         3'h6
`define SWRMC_MODE_RST        32'h5555_5555
`define SWRMC_SEQ_COVER       8'h7F
`define SWRMC_MODE_OFF        2'h0

`endif

// ---- swrmc_pkg.sv ----
`default_nettype none
package swrmc_pkg;
  localparam int NRES = 8;

  typedef enum logic [5:0] {
    ST_ACTIVE = 6'b000001,
    ST_A2S    = 6'b000010,
    ST_SLEEP  = 6'b000100,
    ST_S2A    = 6'b001000,
    ST_S2OFF  = 6'b010000,
    ST_OFF    = 6'b100000
  } swrmc_state_t;

  typedef struct packed {
    swrmc_state_t state;
    logic         step_wait;
    logic [2:0]   idx;
    logic [7:0]   seq_sleep;
    logic [7:0]   seq_off;
    logic [1:0]   ctrl;
    logic [2:0]   pol;
    logic [7:0]   a_slp;
    logic [7:0]   a_ena;
    logic [7:0]   a_enb;
    logic [31:0]  mode;
    logic [7:0]   sw_en;
    logic         ap_valid;
    logic         ap_write;
    logic         ap_hit;
    logic [2:0]   ap_idx;
    logic [31:0]  rdata;
    logic [15:0]  out_mode;
    logic [7:0]   out_sleep;
    logic [7:0]   out_on;
  } swrmc_main_t;

  typedef struct packed {
    logic        busy;
    logic [15:0] div;
    logic [15:0] cnt;
  } swrmc_timer_t;

  typedef struct packed {
    logic level;
  } swrmc_pin_t;
endpackage : swrmc_pkg
`default_nettype wire

// ---- swrmc_step_if.sv ----
`default_nettype none
interface swrmc_step_if;
  logic start;
  logic done;
  modport seq (output start, input done);
  modport tmr (input start, output done);
endinterface : swrmc_step_if
`default_nettype wire

// ---- swrmc_pin_sampler.sv ----
`default_nettype none
module swrmc_pin_sampler
  import swrmc_pkg::*;
(
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic pin,
  input  wire logic active_high,
  output logic      asserted_q
);
  swrmc_pin_t st_q;
  swrmc_pin_t st_d;

  // fold polarity in before the flop so downstream only sees the active level
  always_comb begin
    st_d       = st_q;
    st_d.level = active_high ? pin : ~pin;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign asserted_q = st_q.level;
endmodule : swrmc_pin_sampler
`default_nettype wire

// ---- swrmc_step_timer.sv ----
`default_nettype none
`include "swrmc_regs.svh"
module swrmc_step_timer
  import swrmc_pkg::*;
#(
  parameter int STEP_US = `SWRMC_STEP_TIME_US,
  parameter int TICK    = `SWRMC_TICK_CYCLES
)(
  input  wire logic clk,
  input  wire logic srst,
  swrmc_step_if.tmr step
);
  swrmc_timer_t st_q;
  swrmc_timer_t st_d;
  logic         tick;

  // microsecond enable from the divider keeps the step counter narrow
  assign tick      = st_q.busy && (st_q.div == 16'(TICK - 1));
  assign step.done = tick && (st_q.cnt == 16'(STEP_US - 1));

  always_comb begin
    st_d = st_q;
    if (step.start && !st_q.busy) begin
      st_d.busy = 1'b1;
      st_d.div  = '0;
      st_d.cnt  = '0;
    end else if (st_q.busy) begin
      if (tick) begin
        st_d.div = '0;
        if (step.done) begin
          st_d.busy = 1'b0;
        end else begin
          st_d.cnt = st_q.cnt + 16'h0001;
        end
      end else begin
        st_d.div = st_q.div + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  a_step_start_busy : assert property (@(posedge clk) disable iff (srst)
    step.start && !st_q.busy |=> st_q.busy && st_q.cnt == 16'h0000)
    else $error("step timer did not start");
  a_step_done_busy : assert property (@(posedge clk) disable iff (srst)
    step.done |-> st_q.busy && $past(st_q.busy))
    else $error("step done without running timer");
endmodule : swrmc_step_timer
`default_nettype wire

// ---- swrmc_host_model.sv ----
`default_nettype none
// host side: drives the sleep, enable and interrupt lines as plain levels
module swrmc_host_model (
  input  wire logic clk,
  output logic      sleep_request_n_pin,
  output logic      resource_enable_a_pin,
  output logic      resource_enable_b_pin,
  output logic      irq_pending,
  output logic      wake_irq
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle levels: sleep line released high, both enables asserted high
  initial begin
    sleep_request_n_pin   = 1'b1;
    resource_enable_a_pin = 1'b1;
    resource_enable_b_pin = 1'b1;
    irq_pending           = 1'b0;
    wake_irq              = 1'b0;
  end

  // levels change only right after an edge, held until the next call
  task automatic set_pins(input logic s, input logic a, input logic b, input logic irq);
    @(posedge clk);
    sleep_request_n_pin   <= s;
    resource_enable_a_pin <= a;
    resource_enable_b_pin <= b;
    irq_pending           <= irq;
  endtask : set_pins

  // one-cycle interrupt wake event
  task automatic pulse_wake();
    @(posedge clk);
    wake_irq <= 1'b1;
    @(posedge clk);
    wake_irq <= 1'b0;
  endtask : pulse_wake
endmodule : swrmc_host_model
`default_nettype wire

// ---- swrmc_sleep_wake_ctrl_tb.sv ----
`default_nettype none
`include "swrmc_regs.svh"
module swrmc_sleep_wake_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk;
  logic        srst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  wire  logic  hready;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        slp_n;
  logic        ena;
  logic        enb;
  logic        irq;
  logic        wk;
  logic [15:0] res_mode;
  logic [7:0]  res_sleep;
  logic [7:0]  res_on;
  logic        seq_busy;
  int          tests_run;
  int          fail_count;

  // single slave, so its ready is the bus ready
  assign hready = hreadyout;

  // short step interval keeps each sequence a few hundred cycles
  swrmc_sleep_wake_ctrl #(.STEP_TIME_US(2)) DUT (
    .clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .sleep_request_n_pin(slp_n), .resource_enable_a_pin(ena),
    .resource_enable_b_pin(enb), .irq_pending(irq), .wake_irq(wk), .res_mode(res_mode),
    .res_sleep(res_sleep), .res_on(res_on), .seq_busy(seq_busy)
  );

  swrmc_host_model host (
    .clk(clk), .sleep_request_n_pin(slp_n), .resource_enable_a_pin(ena),
    .resource_enable_b_pin(enb), .irq_pending(irq), .wake_irq(wk)
  );

  // 25 MHz clock
  always #20 clk = ~clk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic give_verdict();
    $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict

  // one single AHB transfer; waits on ready in both phases, data taken at the second
  task automatic xfer(input logic w, input logic [7:0] ofs, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, ofs};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
  endtask : xfer

  task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, ofs, d, r);
  endtask : wr

  task automatic rd(input logic [7:0] ofs, input logic [31:0] exp);
    logic [31:0] r;
    xfer(1'b0, ofs, 32'h0000_0000, r);
    chk(r, exp);
    chk({31'h0, hresp}, 32'h0000_0000);
  endtask : rd

  // let registered outputs land before looking at them
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : settle

  // poll the state field; bounded so a stuck sequencer still ends here
  task automatic wait_state(input logic [5:0] st);
    logic [31:0] r;
    int          n;
    n = 0;
    r = 32'h0000_0000;
    while (r[5:0] !== st && n < 400) begin
      xfer(1'b0, `SWRMC_OFS_STATUS, 32'h0000_0000, r);
      n++;
    end
    chk({26'h000_0000, r[5:0]}, {26'h000_0000, st});
  endtask : wait_state

  task automatic t_reset();
    rd(`SWRMC_OFS_CTRL, 32'h0000_0001);
    rd(`SWRMC_OFS_POLARITY, 32'h0000_0006);
    rd(`SWRMC_OFS_MODE_CTRL, 32'h5555_5555);
    rd(`SWRMC_OFS_STATUS, 32'h007F_0001);
    rd(8'h20, 32'h0000_0000);
    $display("test reset done");
  endtask : t_reset

  task automatic t_enable();
    wr(`SWRMC_OFS_ENA_ASGN, 32'h0000_000E);
    wr(`SWRMC_OFS_SLEEP_ASGN, 32'h0000_0023);
    host.set_pins(1'b1, 1'b0, 1'b1, 1'b0);
    settle(3);
    chk({24'h00_0000, res_sleep}, 32'h0000_000C);
    host.set_pins(1'b1, 1'b1, 1'b1, 1'b0);
    settle(3);
    chk({24'h00_0000, res_sleep}, 32'h0000_0000);
    $display("test enable done");
  endtask : t_enable

  task automatic t_sleep();
    int n;
    wr(`SWRMC_OFS_MODE_CTRL, 32'h5555_5559);
    host.set_pins(1'b0, 1'b1, 1'b1, 1'b1);
    settle(6);
    rd(`SWRMC_OFS_STATUS, 32'h007F_0001);
    wr(`SWRMC_OFS_CTRL, 32'h0000_0000);
    settle(6);
    rd(`SWRMC_OFS_STATUS, 32'h007F_0001);
    host.set_pins(1'b0, 1'b1, 1'b1, 1'b0);
    n = 0;
    while (res_sleep === 8'h00 && n < 200) begin
      @(negedge clk);
      n++;
    end
    chk({24'h00_0000, res_sleep}, 32'h0000_0001);
    chk({31'h0, seq_busy}, 32'h0000_0001);
    settle(250);
    chk({31'h0, res_sleep[5]}, 32'h0000_0000);
    wait_state(6'h04);
    chk({24'h00_0000, res_sleep}, 32'h0000_0021);
    chk({30'h0, res_mode[1:0]}, 32'h0000_0002);
    chk({30'h0, res_mode[11:10]}, 32'h0000_0001);
    $display("test sleep done");
  endtask : t_sleep

  task automatic t_wake();
    // masking first keeps the still-low sleep line from re-entering sleep
    wr(`SWRMC_OFS_CTRL, 32'h0000_0001);
    host.set_pins(1'b0, 1'b1, 1'b0, 1'b0);
    settle(4);
    host.set_pins(1'b0, 1'b1, 1'b1, 1'b0);
    settle(4);
    rd(`SWRMC_OFS_STATUS, 32'h007F_2104);
    host.pulse_wake();
    wait_state(6'h01);
    chk({24'h00_0000, res_sleep}, 32'h0000_0000);
    host.set_pins(1'b1, 1'b1, 1'b1, 1'b0);
    $display("test wake done");
  endtask : t_wake

  task automatic t_off();
    wr(`SWRMC_OFS_POLARITY, 32'h0000_0003);
    wr(`SWRMC_OFS_ENB_ASGN, 32'h0000_0010);
    settle(3);
    chk({24'h00_0000, res_sleep}, 32'h0000_0010);
    host.set_pins(1'b1, 1'b1, 1'b0, 1'b0);
    settle(3);
    chk({24'h00_0000, res_sleep}, 32'h0000_0000);
    wr(`SWRMC_OFS_SW_EN, 32'h0000_0080);
    settle(2);
    chk({24'h00_0000, res_on}, 32'h0000_00FF);
    wr(`SWRMC_OFS_CTRL, 32'h0000_0002);
    settle(4);
    wr(`SWRMC_OFS_SW_EN, 32'h0000_0000);
    wait_state(6'h04);
    chk({31'h0, res_on[7]}, 32'h0000_0001);
    host.set_pins(1'b0, 1'b1, 1'b0, 1'b0);
    wait_state(6'h20);
    chk({24'h00_0000, res_on}, 32'h0000_0000);
    $display("test off done");
  endtask : t_off

  // watchdog: several times the expected run length
  initial begin
    repeat (12000) @(posedge clk);
    fail_count++;
    give_verdict();
  end

  // reset, then the scenarios in order
  initial begin
    clk        = 1'b0;
    srst       = 1'b1;
    hsel       = 1'b0;
    haddr      = 32'h0000_0000;
    htrans     = 2'h0;
    hwrite     = 1'b0;
    hsize      = 3'h2;
    hwdata     = 32'h0000_0000;
    tests_run  = 0;
    fail_count = 0;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_enable();
    t_sleep();
    t_wake();
    t_off();
    give_verdict();
  end
endmodule : swrmc_sleep_wake_ctrl_tb
`default_nettype wire
